//--- common/ulsr_consts.svh
// Register offsets, field positions, reset values and timing counts of the line status block.
`ifndef ULSR_CONSTS_SVH
`define ULSR_CONSTS_SVH

`define ULSR_ADDR_W          12
`define ULSR_OFF_DATA        12'h000
`define ULSR_OFF_CTRL        12'h004
`define ULSR_OFF_DIVISOR     12'h008
`define ULSR_OFF_LINE_STATUS 12'h00C
`define ULSR_OFF_INT_STATUS  12'h010
`define ULSR_OFF_INT_MASK    12'h014

`define ULSR_CTRL_FIFO_EN    0
`define ULSR_CTRL_LEN_LO     1
`define ULSR_CTRL_LEN_HI     2
`define ULSR_CTRL_PAR_EN     3
`define ULSR_CTRL_PAR_EVEN   4

`define ULSR_DIVISOR_RESET   16'h0001

`define ULSR_INT_THR_EMPTY   0
`define ULSR_INT_RX_ERROR    1
`define ULSR_INT_BREAK       2
`define ULSR_INT_RX_CHAR     3
`define ULSR_INT_W           4

`define ULSR_OVERSAMPLE      5'h10
`define ULSR_MID_SAMPLE      4'h7
`define ULSR_LAST_TICK       4'hF
`define ULSR_MIN_BITS        4'h5

`endif

//--- common/ulsr_pkg.sv
// Shared types of the line status block.
package ulsr_pkg;

  typedef enum logic [2:0] {
    ULSR_RX_IDLE,
    ULSR_RX_START,
    ULSR_RX_DATA,
    ULSR_RX_PARITY,
    ULSR_RX_STOP,
    ULSR_RX_BRK_WAIT
  } ulsr_rx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       pe;
    logic       fe;
    logic       bi;
  } ulsr_entry_t;

endpackage : ulsr_pkg

//--- dv/tb_top.sv
// Self-checking bench of the line status block with far-side model.
`timescale 1ns/10ps
`include "ulsr_consts.svh"

module tb_top;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] msk;
    logic        err;
  } ulsr_note_t;

  logic                    pclk;
  logic                    presetn;
  logic [`ULSR_ADDR_W-1:0] paddr;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    rx_pin;
  logic                    tx_pop;
  logic                    tx_shift_empty;
  logic                    tx_push;
  logic [7:0]              tx_push_data;
  logic                    irq;
  logic                    slow;
  ulsr_note_t              q[$];
  ulsr_note_t              nt;
  int                      n_mismatch;
  int                      n_tests;

  ulsr_line_status i_ulsr_line_status (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .tx_pop(tx_pop), .tx_shift_empty(tx_shift_empty), .tx_push(tx_push),
    .tx_push_data(tx_push_data), .irq(irq)
  );
  ulsr_far_model i_far (
    .pclk(pclk), .presetn(presetn), .tx_push(tx_push), .slow(slow), .rx_pin(rx_pin),
    .tx_pop(tx_pop), .tx_shift_empty(tx_shift_empty)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    q.push_back('{e, m, err});
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task automatic chk(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: irq level wrong", $time);
    end
  endtask : chk

  function automatic logic [40:0] frm(input logic [7:0] d, input logic p, input logic s);
    return 41'({s, p, d, 1'b0});
  endfunction : frm

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      nt = q.pop_front();
      n_tests++;
      if ((prdata & nt.msk) !== nt.exp || pslverr !== nt.err) begin
        n_mismatch++;
        $display("unexpected at %0t: read %h gave %h", $time, paddr, prdata);
      end
    end
  end

  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [7:0] d [3];
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b1;
    void'($urandom(32'h7167));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ULSR_OFF_LINE_STATUS, 32'h60, 32'hFF, 1'b0);
    rd(12'h018, 32'h0, 32'hFFFFFFFF, 1'b1);
    $display("test reset done");
    xfer(`ULSR_OFF_DATA, 1'b1, 32'($urandom & 32'hFF));
    rd(`ULSR_OFF_LINE_STATUS, 32'h00, 32'h60, 1'b0);
    repeat (80) @(posedge pclk);
    rd(`ULSR_OFF_LINE_STATUS, 32'h20, 32'h60, 1'b0);
    repeat (80) @(posedge pclk);
    rd(`ULSR_OFF_LINE_STATUS, 32'h60, 32'h60, 1'b0);
    $display("test plain transmit done");
    xfer(`ULSR_OFF_CTRL, 1'b1, 32'h07);
    xfer(`ULSR_OFF_INT_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b1);
    for (int i = 0; i < 2; i++) xfer(`ULSR_OFF_DATA, 1'b1, 32'($urandom & 32'hFF));
    xfer(`ULSR_OFF_INT_STATUS, 1'b1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h00, 32'h60, 1'b0);
    repeat (400) @(posedge pclk);
    rd(`ULSR_OFF_LINE_STATUS, 32'h60, 32'h60, 1'b0);
    chk(irq === 1'b1);
    xfer(`ULSR_OFF_INT_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b0);
    $display("test queued transmit done");
    for (int i = 0; i < 3; i++) d[i] = 8'($urandom);
    d[2] = d[2] | 8'h01;
    xfer(`ULSR_OFF_CTRL, 1'b1, 32'h1F);
    i_far.send(frm(d[0], ^d[0], 1'b1), 11);
    i_far.send(frm(d[1], ~^d[1], 1'b1), 11);
    i_far.send(frm(d[2], ^d[2], 1'b0), 11);
    i_far.send(41'h0, 41);
    rd(`ULSR_OFF_INT_STATUS, 32'hE, 32'hE, 1'b0);
    xfer(`ULSR_OFF_INT_STATUS, 1'b1, 32'hF);
    rd(`ULSR_OFF_LINE_STATUS, 32'h80, 32'h9C, 1'b0);
    rd(`ULSR_OFF_DATA, 32'(d[0]), 32'hFF, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h84, 32'h9C, 1'b0);
    rd(`ULSR_OFF_DATA, 32'(d[1]), 32'hFF, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h88, 32'h9C, 1'b0);
    rd(`ULSR_OFF_DATA, 32'(d[2]), 32'hFF, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h98, 32'h9C, 1'b0);
    rd(`ULSR_OFF_DATA, 32'h0, 32'hFF, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h80, 32'h9C, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h00, 32'h9C, 1'b0);
    $display("test receive errors done");
    xfer(`ULSR_OFF_CTRL, 1'b1, 32'h08);
    xfer(`ULSR_OFF_DIVISOR, 1'b1, 32'h0);
    rd(`ULSR_OFF_DIVISOR, 32'h1, 32'hFFFFFFFF, 1'b0);
    // Five data bits with odd parity; the second character overwrites the first.
    i_far.send(41'({1'b1, ~^d[0][4:0], d[0][4:0], 1'b0}), 8);
    i_far.send(41'({1'b1, ^d[1][4:0], d[1][4:0], 1'b0}), 8);
    rd(`ULSR_OFF_LINE_STATUS, 32'h84, 32'h9C, 1'b0);
    rd(`ULSR_OFF_DATA, 32'({3'b000, d[1][4:0]}), 32'hFF, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h80, 32'h9C, 1'b0);
    rd(`ULSR_OFF_LINE_STATUS, 32'h00, 32'h9C, 1'b0);
    $display("test plain receive done");
    summarize();
  end
endmodule : tb_top

//--- dv/ulsr_far_model.sv
// Far-side model: serial line source and transmitter shift register.
`timescale 1ns/10ps

module ulsr_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_push,
  input  wire logic slow,
  output logic      rx_pin,
  output logic      tx_pop,
  output logic      tx_shift_empty
);
  int   pend;
  int   cnt;
  int   lat;
  logic busy;

  assign lat = slow ? 60 : 3;
  assign tx_shift_empty = !busy;
  initial rx_pin = 1'b1;

  // A character waits lat+1 cycles before it is taken, then shifts out for lat+1 cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 0;
      cnt <= 0;
      busy <= 1'b0;
      tx_pop <= 1'b0;
    end else begin
      pend <= pend + int'(tx_push) - int'(tx_pop);
      tx_pop <= 1'b0;
      if (busy || pend != 0) cnt <= cnt + 1;
      if (cnt >= lat) begin
        cnt <= 0;
        busy <= !busy;
        tx_pop <= !busy;
      end
    end
  end

  task automatic send(input logic [40:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_pin <= bits[i];
      repeat (16) @(posedge pclk);
    end
    rx_pin <= 1'b1;
    repeat (48) @(posedge pclk);
  endtask : send
endmodule : ulsr_far_model

//--- dv/ulsr_line_status_asserts.sv
// Checker on the ports of the line status block, bound into every instance.
`timescale 1ns/10ps
`include "ulsr_consts.svh"

module ulsr_line_status_asserts (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [`ULSR_ADDR_W-1:0] paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    rx_pin,
  input wire logic                    tx_pop,
  input wire logic                    tx_shift_empty,
  input wire logic                    tx_push,
  input wire logic [7:0]              tx_push_data,
  input wire logic                    irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire done  = psel && penable && pready;
  wire rd_ls = done && !pwrite && paddr == `ULSR_OFF_LINE_STATUS;
  wire unmap = paddr[1:0] != 2'h0 || paddr > `ULSR_OFF_INT_MASK;

  property p_wait;
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("access did not end after one wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held longer than one cycle");
  property p_err;
    done && unmap |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_push_cause;
    tx_push |-> $past(done && pwrite && paddr == `ULSR_OFF_DATA);
  endproperty
  a_push_cause: assert property (p_push_cause) else $error("push without data write");
  property p_push_data;
    tx_push |-> tx_push_data == $past(pwdata[7:0]);
  endproperty
  a_push_data: assert property (p_push_data) else $error("pushed character differs");
  property p_ls_zero;
    rd_ls |-> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0;
  endproperty
  a_ls_zero: assert property (p_ls_zero) else $error("unused status bits not zero");
  property p_sum;
    rd_ls && (|prdata[4:2]) |-> prdata[7];
  endproperty
  a_sum: assert property (p_sum) else $error("head error without summary");
  property p_empty;
    rd_ls && prdata[6] |-> prdata[5];
  endproperty
  a_empty: assert property (p_empty) else $error("all empty while holding full");
endmodule : ulsr_line_status_asserts

bind ulsr_line_status ulsr_line_status_asserts i_ulsr_line_status_asserts (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_pin(rx_pin), .tx_pop(tx_pop), .tx_shift_empty(tx_shift_empty), .tx_push(tx_push),
  .tx_push_data(tx_push_data), .irq(irq)
);

//--- rtl/ulsr_line_status.sv
// UART line status upper bits with receive tag FIFO, transmit occupancy and APB registers.
//
// How it works
// - Bit 7 sets while any receive FIFO character carries parity, framing or break.
// - Reading line status clears the bit 7 error summary.
// - Non-FIFO mode: bit 6 is one only while holding and shift registers are empty.
// - FIFO mode: bit 6 sets only when transmit FIFO and shift register are empty.
// - Non-FIFO: bit 5 sets on move to shift register, clears on host write.
// - With its enable set, holding-empty raises an interrupt request whenever set.
// - FIFO mode: bit 5 sets when transmit FIFO empties, clears on any data register write.
// - Bit 4 sets when the receive line stays low for a whole frame.
// - FIFO mode: one break character enters the FIFO per break.
// - Bit 3 sets when a received character lacks a valid stop bit.
// - FIFO mode: framing flag reflects the character at the FIFO head.
// - After reset the summary, break and framing flags read zero.
// - Parity mismatch flags bit 2 for the head character and feeds bit 7.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "ulsr_consts.svh"

module ulsr_line_status #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [`ULSR_ADDR_W-1:0] paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    rx_pin,
  input  wire logic                    tx_pop,
  input  wire logic                    tx_shift_empty,
  output logic                         tx_push,
  output logic [7:0]                   tx_push_data,
  output logic                         irq
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    ulsr_pkg::ulsr_entry_t [FIFO_DEPTH-1:0] mem;
    logic [PW-1:0]                          rd_ptr;
    logic [PW-1:0]                          wr_ptr;
    logic [CW-1:0]                          rx_count;
    logic [CW-1:0]                          err_count;
    logic [CW-1:0]                          tx_level;
    logic                                   fifo_en;
    logic [1:0]                             char_len;
    logic                                   par_en;
    logic                                   par_even;
    logic [15:0]                            divisor;
    logic                                   summary;
    logic                                   thr_empty;
    logic                                   tx_empty;
    logic [`ULSR_INT_W-1:0]                 int_status;
    logic [`ULSR_INT_W-1:0]                 int_mask;
    logic [31:0]                            prdata;
    logic                                   pready;
    logic                                   pslverr;
    logic                                   tx_push;
    logic [7:0]                             tx_push_data;
    logic                                   irq;
  } ulsr_state_t;

  ulsr_state_t s;
  ulsr_state_t next_s;

  logic                  char_valid;
  logic [7:0]            char_data;
  logic                  char_pe;
  logic                  char_fe;
  logic                  char_bi;
  ulsr_pkg::ulsr_entry_t head;
  ulsr_pkg::ulsr_entry_t new_entry;
  logic                  have_rx;
  logic                  new_err;
  logic                  head_err;
  logic                  acc;
  logic                  done;
  logic                  lsr_rd;
  logic                  rx_pop;
  logic                  push_err;
  logic [7:0]            line_status;
  logic [CW-1:0]         tx_cap;
  logic [`ULSR_INT_W-1:0] int_set;
  logic [`ULSR_INT_W-1:0] int_clr;

  ulsr_rx_framer u_framer (
    .pclk       (pclk),
    .presetn    (presetn),
    .rx_pin     (rx_pin),
    .char_len   (s.char_len),
    .par_en     (s.par_en),
    .par_even   (s.par_even),
    .divisor    (s.divisor),
    .char_valid (char_valid),
    .char_data  (char_data),
    .char_pe    (char_pe),
    .char_fe    (char_fe),
    .char_bi    (char_bi)
  );

  always_comb begin
    next_s         = s;
    next_s.tx_push = 1'b0;
    head           = s.mem[s.rd_ptr];
    have_rx        = (s.rx_count != '0);
    head_err       = head.pe | head.fe | head.bi;
    new_entry      = '{data: char_data, pe: char_pe, fe: char_fe, bi: char_bi};
    new_err        = char_pe | char_fe | char_bi;
    push_err       = char_valid & new_err;
    tx_cap         = s.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
    acc            = psel & penable;
    done           = acc & s.pready;
    lsr_rd         = 1'b0;
    rx_pop         = 1'b0;
    int_clr        = '0;

    // Head tags are shown only while a character is held.
    line_status = {s.summary, s.tx_empty, s.thr_empty,
                   have_rx & head.bi,
                   have_rx & head.fe,
                   have_rx & head.pe,
                   2'b00};

    // One wait state: data and error are captured in the first access cycle.
    next_s.pready = acc & ~s.pready;
    if (acc && !s.pready) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
      unique case (paddr)
        `ULSR_OFF_DATA: begin
          next_s.prdata = {24'h00_0000, have_rx ? head.data : 8'h00};
        end
        `ULSR_OFF_CTRL: begin
          next_s.prdata = {27'h000_0000, s.par_even, s.par_en, s.char_len, s.fifo_en};
        end
        `ULSR_OFF_DIVISOR: begin
          next_s.prdata = {16'h0000, s.divisor};
        end
        `ULSR_OFF_LINE_STATUS: begin
          next_s.prdata = {24'h00_0000, line_status};
        end
        `ULSR_OFF_INT_STATUS: begin
          next_s.prdata = {28'h000_0000, s.int_status};
        end
        `ULSR_OFF_INT_MASK: begin
          next_s.prdata = {28'h000_0000, s.int_mask};
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    if (done && !s.pslverr) begin
      if (pwrite) begin
        unique case (paddr)
          `ULSR_OFF_DATA: begin
            // A write into a full holding store is dropped.
            if (s.tx_level < tx_cap) begin
              next_s.tx_push      = 1'b1;
              next_s.tx_push_data = pwdata[7:0];
              next_s.tx_level     = s.tx_level + CW'(1);
            end
          end
          `ULSR_OFF_DIVISOR: begin
            next_s.divisor = (pwdata[15:0] == 16'h0000) ? `ULSR_DIVISOR_RESET : pwdata[15:0];
          end
          `ULSR_OFF_INT_STATUS: begin
            int_clr = pwdata[`ULSR_INT_W-1:0];
          end
          `ULSR_OFF_INT_MASK: begin
            next_s.int_mask = pwdata[`ULSR_INT_W-1:0];
          end
          default: begin
          end
        endcase
      end else begin
        rx_pop = (paddr == `ULSR_OFF_DATA) && have_rx;
        lsr_rd = (paddr == `ULSR_OFF_LINE_STATUS);
      end
    end

    // The transmitter takes a character into its shift register.
    if (tx_pop && next_s.tx_level != '0) begin
      next_s.tx_level = next_s.tx_level - CW'(1);
    end

    if (rx_pop) begin
      if (s.fifo_en) begin
        next_s.rd_ptr = s.rd_ptr + PW'(1);
      end
      next_s.rx_count = s.rx_count - CW'(1);
      if (head_err) begin
        next_s.err_count = s.err_count - CW'(1);
      end
    end

    if (char_valid) begin
      if (!s.fifo_en) begin
        // Without the FIFO a new character overwrites the single holding slot.
        next_s.mem[0]    = new_entry;
        next_s.rd_ptr    = '0;
        next_s.wr_ptr    = '0;
        next_s.rx_count  = CW'(1);
        next_s.err_count = new_err ? CW'(1) : CW'(0);
      end else if (next_s.rx_count < CW'(FIFO_DEPTH)) begin
        next_s.mem[s.wr_ptr] = new_entry;
        next_s.wr_ptr        = s.wr_ptr + PW'(1);
        next_s.rx_count      = next_s.rx_count + CW'(1);
        if (new_err) begin
          next_s.err_count = next_s.err_count + CW'(1);
        end
      end
    end

    // A mode change empties both stores so stale entries are never shown.
    if (done && !s.pslverr && pwrite && paddr == `ULSR_OFF_CTRL) begin
      next_s.fifo_en  = pwdata[`ULSR_CTRL_FIFO_EN];
      next_s.char_len = pwdata[`ULSR_CTRL_LEN_HI:`ULSR_CTRL_LEN_LO];
      next_s.par_en   = pwdata[`ULSR_CTRL_PAR_EN];
      next_s.par_even = pwdata[`ULSR_CTRL_PAR_EVEN];
      if (pwdata[`ULSR_CTRL_FIFO_EN] != s.fifo_en) begin
        next_s.rd_ptr    = '0;
        next_s.wr_ptr    = '0;
        next_s.rx_count  = '0;
        next_s.err_count = '0;
        next_s.tx_level  = '0;
      end
    end

    // Set wins over the read clear; errors still held set it again.
    next_s.summary = push_err
                   | (~lsr_rd & (s.err_count != '0))
                   | (~lsr_rd & s.summary);

    next_s.thr_empty = (next_s.tx_level == '0);
    next_s.tx_empty  = (next_s.tx_level == '0) & tx_shift_empty;

    int_set                      = '0;
    int_set[`ULSR_INT_THR_EMPTY] = next_s.thr_empty;
    int_set[`ULSR_INT_RX_ERROR]  = push_err;
    int_set[`ULSR_INT_BREAK]     = char_valid & char_bi;
    int_set[`ULSR_INT_RX_CHAR]   = char_valid;
    next_s.int_status = (s.int_status & ~int_clr) | int_set;
    next_s.irq        = |(next_s.int_status & next_s.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.divisor   <= `ULSR_DIVISOR_RESET;
      s.thr_empty <= 1'b1;
      s.tx_empty  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign tx_push      = s.tx_push;
  assign tx_push_data = s.tx_push_data;
  assign irq          = s.irq;

endmodule : ulsr_line_status

//--- rtl/ulsr_rx_framer.sv
// Serial receive framer: samples the line, checks parity and stop bit, and reports breaks.
`timescale 1ns/10ps
`include "ulsr_consts.svh"

module ulsr_rx_framer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rx_pin,
  input  wire logic [1:0]  char_len,
  input  wire logic        par_en,
  input  wire logic        par_even,
  input  wire logic [15:0] divisor,
  output logic             char_valid,
  output logic [7:0]       char_data,
  output logic             char_pe,
  output logic             char_fe,
  output logic             char_bi
);

  typedef struct packed {
    logic                    rx_meta;
    logic                    rx_sync;
    logic [15:0]             div_cnt;
    logic [3:0]              tick;
    logic [3:0]              bit_idx;
    ulsr_pkg::ulsr_rx_state_t state;
    logic [7:0]              shreg;
    logic                    par_acc;
    logic                    all_low;
    logic                    pe;
    logic                    valid;
    logic [7:0]              data;
    logic                    fe;
    logic                    bi;
  } ulsr_fr_state_t;

  ulsr_fr_state_t s;
  ulsr_fr_state_t next_s;

  logic [3:0] nbits;
  logic       baud;
  logic       mid;
  logic       par_exp;

  always_comb begin
    next_s         = s;
    next_s.valid   = 1'b0;
    next_s.rx_meta = rx_pin;
    next_s.rx_sync = s.rx_meta;
    nbits          = `ULSR_MIN_BITS + {2'b00, char_len};
    baud           = (s.div_cnt == 16'h0000);
    next_s.div_cnt = baud ? (divisor - 16'h0001) : (s.div_cnt - 16'h0001);
    mid            = baud && (s.tick == `ULSR_LAST_TICK);
    par_exp        = par_even ? s.par_acc : ~s.par_acc;
    if (baud) begin
      next_s.tick = s.tick + 4'h1;
    end
    unique case (s.state)
      ulsr_pkg::ULSR_RX_IDLE: begin
        next_s.tick = 4'h0;
        if (!s.rx_sync) begin
          next_s.state   = ulsr_pkg::ULSR_RX_START;
          next_s.all_low = 1'b1;
          next_s.par_acc = 1'b0;
          next_s.pe      = 1'b0;
          next_s.bit_idx = 4'h0;
          next_s.shreg   = 8'h00;
        end
      end
      ulsr_pkg::ULSR_RX_START: begin
        if (baud && s.tick == `ULSR_MID_SAMPLE) begin
          next_s.tick = 4'h0;
          // A glitch shorter than half a bit is not a start bit.
          next_s.state = s.rx_sync ? ulsr_pkg::ULSR_RX_IDLE : ulsr_pkg::ULSR_RX_DATA;
        end
      end
      ulsr_pkg::ULSR_RX_DATA: begin
        if (mid) begin
          next_s.shreg   = {s.rx_sync, s.shreg[7:1]};
          next_s.par_acc = s.par_acc ^ s.rx_sync;
          next_s.all_low = s.all_low & ~s.rx_sync;
          next_s.bit_idx = s.bit_idx + 4'h1;
          if (s.bit_idx + 4'h1 == nbits) begin
            next_s.state = par_en ? ulsr_pkg::ULSR_RX_PARITY : ulsr_pkg::ULSR_RX_STOP;
          end
        end
      end
      ulsr_pkg::ULSR_RX_PARITY: begin
        if (mid) begin
          next_s.pe      = (s.rx_sync != par_exp);
          next_s.all_low = s.all_low & ~s.rx_sync;
          next_s.state   = ulsr_pkg::ULSR_RX_STOP;
        end
      end
      ulsr_pkg::ULSR_RX_STOP: begin
        if (mid) begin
          next_s.valid = 1'b1;
          next_s.data  = s.shreg >> (4'h8 - nbits);
          next_s.pe    = s.pe;
          next_s.fe    = ~s.rx_sync;
          next_s.bi    = s.all_low & ~s.rx_sync;
          // One break character per break, then wait for the line to recover.
          next_s.state = (s.all_low & ~s.rx_sync) ? ulsr_pkg::ULSR_RX_BRK_WAIT
                                                 : ulsr_pkg::ULSR_RX_IDLE;
        end
      end
      ulsr_pkg::ULSR_RX_BRK_WAIT: begin
        if (s.rx_sync) begin
          next_s.state = ulsr_pkg::ULSR_RX_IDLE;
        end
      end
      default: begin
        next_s.state = ulsr_pkg::ULSR_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s         <= '0;
      s.rx_meta <= 1'b1;
      s.rx_sync <= 1'b1;
      s.state   <= ulsr_pkg::ULSR_RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign char_valid = s.valid;
  assign char_data  = s.data;
  assign char_pe    = s.pe;
  assign char_fe    = s.fe;
  assign char_bi    = s.bi;

endmodule : ulsr_rx_framer
